// file: wdb_pkg.sv
package wdb_pkg;

    // Printed offsets are register indices; the byte address is four times the index
    localparam int                APB_AW       = 12;
    localparam logic [7:0]        MODE_INDEX   = 8'h0F;
    localparam logic [7:0]        STATUS_INDEX = 8'h10;

    function automatic logic [APB_AW-1:0] byte_addr(input logic [7:0] index);
        return {2'b00, index, 2'b00};
    endfunction

    localparam logic [APB_AW-1:0] MODE_ADDR    = byte_addr(MODE_INDEX);
    localparam logic [APB_AW-1:0] STATUS_ADDR  = byte_addr(STATUS_INDEX);

    // Mode register value after power-on, brown-out or watchdog reset
    localparam logic [3:0]        MODE_RESET   = 4'hC;

    // Clocking: clk_in is the crystal clock
    localparam int CLK_HZ               = 40_000_000;
    localparam int CRYSTAL_CLOCK_PER_CPU         = 2;
    localparam int WINDOW_CRYSTAL_CLOCK_CLOCKS   = 120;
    localparam int WINDOW_CPU_CYCLES    = WINDOW_CRYSTAL_CLOCK_CLOCKS / CRYSTAL_CLOCK_PER_CPU;
    localparam int WIN_CNT_W            = $clog2(WINDOW_CPU_CYCLES);
    localparam int RC_HZ_DEFAULT        = 1_000_000;
    localparam int RC_DIV_DEFAULT       = CLK_HZ / RC_HZ_DEFAULT;

    // Counter sizes and lengths in RC ticks
    localparam int WDT_CNT_W            = 16;
    localparam int POR_CNT_W            = 16;
    localparam int POR_RC_TICKS_DEFAULT = 256;
    localparam int TAP0_DEFAULT         = 2048;
    localparam int TAP1_DEFAULT         = 4096;
    localparam int TAP2_DEFAULT         = 8192;
    localparam int TAP3_DEFAULT         = 32768;

    // Last reset cause codes
    localparam logic [1:0] CAUSE_POR      = 2'h0;
    localparam logic [1:0] CAUSE_BROWNOUT = 2'h1;
    localparam logic [1:0] CAUSE_WDT      = 2'h2;

    typedef struct packed {
        logic       stop_run;
        logic       halt_run;
        logic [1:0] time_sel;
    } wdb_mode_t;

    typedef struct packed {
        logic zero;
        logic sign;
        logic overflow;
    } wdb_flags_t;

    localparam wdb_flags_t REFRESH_FLAGS = 3'h4;

    typedef struct packed {
        logic [WDT_CNT_W-1:0]    count;
        logic [26-WDT_CNT_W:0]   unused;
        logic                    cpu_reset;
        logic [1:0]              cause;
        logic                    window_open;
        logic                    running;
    } wdb_status_t;

    typedef enum logic [1:0] {ST_POR, ST_BROWNOUT, ST_RUN} wdb_rst_state_t;

endpackage

// file: wdb_tick_div.sv
`timescale 1ns/1ps
module wdb_tick_div #(
    parameter int DIV = 2
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Divider control
    input  wire logic enable_in,
    output logic      tick_out
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    if (DIV < 1) begin : g_bad_div
        $error("wdb_tick_div: DIV must be at least 1");
    end

    logic [CW-1:0] count;
    wire           last = (count == CW'(DIV - 1));

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count    <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= enable_in & last;
            if (enable_in) begin
                count <= last ? '0 : count + CW'(1);
            end
        end
    end
endmodule // wdb_tick_div

// file: wdb_wdt_counter.sv
`timescale 1ns/1ps
module wdb_wdt_counter
    import wdb_pkg::*;
#(
    parameter int TAP0 = TAP0_DEFAULT,
    parameter int TAP1 = TAP1_DEFAULT,
    parameter int TAP2 = TAP2_DEFAULT,
    parameter int TAP3 = TAP3_DEFAULT
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    // Control
    input  wire logic                 clear_in,
    input  wire logic                 tick_in,
    input  wire logic                 run_in,
    input  wire logic [1:0]           time_sel_in,
    // State
    output logic [WDT_CNT_W-1:0]      count_out,
    output logic                      timeout_out
);
    if (TAP0 < 1 || TAP1 < 1 || TAP2 < 1 || TAP3 < 1 ||
        TAP0 > 2**WDT_CNT_W || TAP1 > 2**WDT_CNT_W ||
        TAP2 > 2**WDT_CNT_W || TAP3 > 2**WDT_CNT_W) begin : g_bad_tap
        $error("wdb_wdt_counter: tap lengths must lie in 1 .. 2**WDT_CNT_W");
    end

    function automatic logic [WDT_CNT_W-1:0] terminal(input logic [1:0] sel);
        case (sel)
            2'b00:   return WDT_CNT_W'(TAP0 - 1);
            2'b01:   return WDT_CNT_W'(TAP1 - 1);
            2'b10:   return WDT_CNT_W'(TAP2 - 1);
            default: return WDT_CNT_W'(TAP3 - 1);
        endcase
    endfunction

    wire step   = tick_in & run_in;
    wire at_end = (count_out == terminal(time_sel_in));

    // A clear in the terminal cycle wins, so a refresh just in time never resets
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_out   <= '0;
            timeout_out <= 1'b0;
        end else if (clear_in) begin
            count_out   <= '0;
            timeout_out <= 1'b0;
        end else begin
            timeout_out <= step & at_end;
            if (step) begin
                count_out <= at_end ? '0 : count_out + WDT_CNT_W'(1);
            end
        end
    end
endmodule // wdb_wdt_counter

// file: wdb_watchdog.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Watchdog is a retriggerable one-shot; terminal count resets the processor.
// - Watchdog stays idle until the first watchdog instruction starts it.
// - Each later watchdog instruction restarts the timeout period.
// - Watchdog counter advances on the on-board RC oscillator, not the crystal.
// - Watchdog instruction updates the zero, sign and overflow flags.
// - Power-on-reset counter also runs from the internal RC oscillator.
// - Mode bits 0 and 1 pick the counter tap setting the minimum timeout.
// - Mode bit 2 decides whether the watchdog counts during halt.
// - Mode bit 3 decides counting during stop; 1 means active, default 1.
// - Mode bits 4 to 7 are reserved and change nothing.
// - Mode writable only for 60 processor cycles after first instruction.
// - Mode register is write-only; reads never return its contents.
// - Mode register sits at index 0Fh of the expanded register bank.
// - Stop halts the crystal, so counters use the RC clock in stop.
// - A one-time option enables the watchdog straight out of power-on reset.
// - Global reset is held while the supply sits below the brown-out threshold.
// - When the supply recovers, a full power-on-reset sequence runs first.
module wdb_watchdog
    import wdb_pkg::*;
#(
    parameter int RC_DIV       = RC_DIV_DEFAULT,
    parameter int POR_RC_TICKS = POR_RC_TICKS_DEFAULT,
    parameter int TAP0         = TAP0_DEFAULT,
    parameter int TAP1         = TAP1_DEFAULT,
    parameter int TAP2         = TAP2_DEFAULT,
    parameter int TAP3         = TAP3_DEFAULT
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [APB_AW-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Processor core
    input  wire logic              instr_exec_in,
    input  wire logic              wdt_instr_in,
    input  wire logic              halt_in,
    input  wire logic              stop_in,
    input  wire logic              stop_mode_recovery_in,
    output wdb_flags_t             flags_out,
    output logic                   flags_write_out,
    // Option and supply
    input  wire logic              otp_wdt_at_por_in,
    input  wire logic              brownout_threshold_low_in,
    // Reset and state
    output logic                   cpu_reset_out,
    output logic                   watchdog_timer_running_out
);
    if (RC_DIV < 1) begin : g_bad_rc
        $error("wdb_watchdog: RC_DIV must be at least 1");
    end
    if (POR_RC_TICKS < 1 || POR_RC_TICKS > 2**POR_CNT_W) begin : g_bad_por
        $error("wdb_watchdog: POR_RC_TICKS out of range");
    end

    // ------------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------------
    logic rc_tick;
    logic cpu_tick;

    // The RC oscillator never stops, so it keeps both counters alive in stop
    wdb_tick_div #(
        .DIV       (RC_DIV)
    ) u_rc_div (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .enable_in (1'b1),
        .tick_out  (rc_tick)
    );

    // Processor cycles come from the crystal and stop with it
    wdb_tick_div #(
        .DIV       (CRYSTAL_CLOCK_PER_CPU)
    ) u_cpu_div (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .enable_in (!stop_in),
        .tick_out  (cpu_tick)
    );

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    wdb_rst_state_t         state;
    wdb_rst_state_t         next_state;
    logic [POR_CNT_W-1:0]   por_cnt;
    logic [POR_CNT_W-1:0]   next_por_cnt;
    logic [1:0]             cause;
    logic [1:0]             next_cause;
    logic                   wdt_timeout;

    wire brownout   = brownout_threshold_low_in;
    wire run_state  = (state == ST_RUN);
    wire por_done   = rc_tick && (por_cnt == POR_CNT_W'(POR_RC_TICKS - 1));
    wire leaving_por = (state == ST_POR) && (next_state == ST_RUN);

    always_comb begin
        next_state = state;
        case (state)
            ST_BROWNOUT: begin
                if (!brownout) begin
                    next_state = ST_POR;
                end
            end
            ST_POR: begin
                if (brownout) begin
                    next_state = ST_BROWNOUT;
                end else if (por_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                if (brownout) begin
                    next_state = ST_BROWNOUT;
                end else if (wdt_timeout) begin
                    next_state = ST_POR;
                end
            end
        endcase
    end

    // The power-on count restarts on every entry, so each reset gets a full sequence
    assign next_por_cnt = (state != ST_POR) ? '0 :
                          rc_tick ? por_cnt + POR_CNT_W'(1) : por_cnt;

    assign next_cause = (next_state == ST_BROWNOUT) ? CAUSE_BROWNOUT :
                        (run_state && next_state == ST_POR) ? CAUSE_WDT : cause;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state         <= ST_POR;
            por_cnt       <= '0;
            cause         <= CAUSE_POR;
            cpu_reset_out <= 1'b1;
        end else begin
            state         <= next_state;
            por_cnt       <= next_por_cnt;
            cause         <= next_cause;
            cpu_reset_out <= (next_state != ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Mode write window
    // ------------------------------------------------------------------
    logic                 win_armed;
    logic                 win_open;
    logic [WIN_CNT_W-1:0] win_cnt;
    logic                 next_win_armed;
    logic                 next_win_open;
    logic [WIN_CNT_W-1:0] next_win_cnt;

    wire stop_mode_recovery       = stop_mode_recovery_in;
    wire win_rearm = !run_state || stop_mode_recovery;
    wire win_start = win_armed && instr_exec_in;
    wire win_last  = cpu_tick && (win_cnt == WIN_CNT_W'(WINDOW_CPU_CYCLES - 1));

    // Window opens at the first instruction after any reset or stop recovery
    assign next_win_armed = win_rearm ? 1'b1 : (win_start ? 1'b0 : win_armed);
    assign next_win_open  = win_rearm ? 1'b0 :
                            win_start ? 1'b1 :
                            (win_open && win_last) ? 1'b0 : win_open;
    assign next_win_cnt   = (win_rearm || win_start) ? '0 :
                            (win_open && cpu_tick) ? win_cnt + WIN_CNT_W'(1) : win_cnt;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            win_armed <= 1'b1;
            win_open  <= 1'b0;
            win_cnt   <= '0;
        end else begin
            win_armed <= next_win_armed;
            win_open  <= next_win_open;
            win_cnt   <= next_win_cnt;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    wdb_mode_t   mode;
    wdb_status_t status;
    logic [31:0] next_prdata;

    wire apb_setup  = psel_in && !penable_in;
    wire apb_access = psel_in && penable_in;
    wire apb_wr     = apb_access && pwrite_in;
    wire is_mode    = (paddr_in == MODE_ADDR);
    wire is_status  = (paddr_in == STATUS_ADDR);
    wire mapped     = is_mode || is_status;
    wire mode_wr    = apb_wr && is_mode && win_open && run_state;

    // Zero wait states; unmapped addresses answer with an error
    assign pready_out  = apb_access;
    assign pslverr_out = apb_access && !mapped;

    // The mode location reads as zero: software cannot learn its setting
    assign next_prdata = (!pwrite_in && is_status) ? status : 32'h0000_0000;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_out <= next_prdata;
        end
    end

    // Stop recovery keeps the mode; the hard resets restore its default
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode <= MODE_RESET;
        end else if (!run_state) begin
            mode <= MODE_RESET;
        end else if (mode_wr) begin
            mode <= pwdata_in[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Watchdog enable, counter and flags
    // ------------------------------------------------------------------
    logic                 wdt_en;
    logic                 next_wdt_en;
    logic [WDT_CNT_W-1:0] wdt_count;

    wire instr_ok   = run_state && wdt_instr_in;
    wire halt_block = halt_in && !mode.halt_run;
    wire stop_block = stop_in && !mode.stop_run;
    wire cnt_run    = wdt_en && run_state && !halt_block && !stop_block;
    wire cnt_clear  = !run_state || !wdt_en || stop_mode_recovery || instr_ok;

    // The option strap is sampled by the clock as the power-on sequence ends
    assign next_wdt_en = !run_state ? (leaving_por && otp_wdt_at_por_in) :
                         (instr_ok ? 1'b1 : wdt_en);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wdt_en <= 1'b0;
        end else begin
            wdt_en <= next_wdt_en;
        end
    end

    wdb_wdt_counter #(
        .TAP0        (TAP0),
        .TAP1        (TAP1),
        .TAP2        (TAP2),
        .TAP3        (TAP3)
    ) u_counter (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .clear_in    (cnt_clear),
        .tick_in     (rc_tick),
        .run_in      (cnt_run),
        .time_sel_in (mode.time_sel),
        .count_out   (wdt_count),
        .timeout_out (wdt_timeout)
    );

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags_out       <= '0;
            flags_write_out <= 1'b0;
        end else begin
            flags_write_out <= instr_ok;
            if (instr_ok) begin
                flags_out <= REFRESH_FLAGS;
            end
        end
    end

    assign watchdog_timer_running_out = wdt_en;

    always_comb begin
        status             = '0;
        status.count       = wdt_count;
        status.cpu_reset   = cpu_reset_out;
        status.cause       = cause;
        status.window_open = win_open;
        status.running     = wdt_en;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    AST_TIMEOUT_RESET: assert property (
        wdt_timeout && !brownout |=> cpu_reset_out && state == ST_POR && cause == CAUSE_WDT)
        else $error("watchdog timeout did not reset the processor");

    AST_IDLE_UNTIL_FIRST: assert property (
        run_state && !wdt_en && !otp_wdt_at_por_in |-> wdt_count == '0 && !wdt_timeout)
        else $error("watchdog counted before being started");

    AST_REFRESH_RESTART: assert property (
        instr_ok && !brownout |=> wdt_en && wdt_count == '0 && !wdt_timeout)
        else $error("watchdog instruction did not restart the period");

    AST_FLAGS_UPDATE: assert property (
        instr_ok |=> flags_write_out && flags_out == REFRESH_FLAGS)
        else $error("flags not updated by watchdog instruction");

    AST_POR_ON_RC: assert property (
        leaving_por |-> rc_tick && por_cnt == POR_CNT_W'(POR_RC_TICKS - 1))
        else $error("power-on sequence ended off the RC count");

    AST_HALT_FREEZE: assert property (
        halt_block && !cnt_clear |=> $stable(wdt_count))
        else $error("watchdog counted in halt while halt counting is off");

    AST_STOP_FREEZE: assert property (
        stop_block && !cnt_clear |=> $stable(wdt_count))
        else $error("watchdog counted in stop while stop counting is off");

    AST_MODE_LOCK: assert property (
        apb_wr && is_mode && !win_open |=> $stable(mode))
        else $error("mode register changed outside its write window");

    AST_WINDOW_CLOSE: assert property (
        run_state && win_open && win_last && !stop_mode_recovery |=> !win_open ##1 !win_open)
        else $error("write window outlived its processor cycles");

    AST_MODE_UNREADABLE: assert property (
        apb_access && !pwrite_in && is_mode |-> prdata_out == 32'h0000_0000 && !pslverr_out)
        else $error("mode register contents leaked on a read");

    AST_BROWNOUT_HOLD: assert property (
        brownout |=> cpu_reset_out && state == ST_BROWNOUT)
        else $error("reset not held during brown-out");

    AST_BROWNOUT_POR: assert property (
        state == ST_BROWNOUT && !brownout |=> state == ST_POR && cpu_reset_out && por_cnt == '0)
        else $error("brown-out recovery skipped the power-on sequence");

endmodule // wdb_watchdog

// file: wdb_core_model.sv
`timescale 1ns/1ps
module wdb_core_model (
    // Clock
    input  wire logic clk_in,
    // Core activity
    output logic      instr_exec_out,
    output logic      wdt_instr_out,
    output logic      halt_out,
    output logic      stop_out,
    output logic      recovery_out
);
    initial begin
        instr_exec_out = 1'b0;
        wdt_instr_out  = 1'b0;
        halt_out       = 1'b0;
        stop_out       = 1'b0;
        recovery_out   = 1'b0;
    end

    // One ordinary instruction, a single-cycle pulse
    task automatic exec();
        instr_exec_out <= 1'b1;
        @(posedge clk_in);
        instr_exec_out <= 1'b0;
    endtask

    // Watchdog instruction: first one starts, later ones restart the count
    task automatic refresh();
        instr_exec_out <= 1'b1;
        wdt_instr_out  <= 1'b1;
        @(posedge clk_in);
        instr_exec_out <= 1'b0;
        wdt_instr_out  <= 1'b0;
    endtask
endmodule // wdb_core_model

// file: wdb_watchdog_tb_top.sv
`timescale 1ns/1ps
module wdb_watchdog_tb_top
    import wdb_pkg::*;
;
    localparam int RCD = 2;
    localparam int T0  = 8;

    logic              clk_in;
    logic              reset_in;
    logic              psel, penable, pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr;
    wire logic         exec_w, wdt_w, halt_w, stop_w, rec_w;
    wdb_flags_t        flags;
    logic              flags_wr, cpu_rst, running;
    logic              otp, bo_low;
    logic [31:0]       rd;
    logic              er;
    int                err_count, comparisons, n;

    wdb_watchdog #(.RC_DIV(RCD), .POR_RC_TICKS(4), .TAP0(T0), .TAP1(16), .TAP2(32), .TAP3(64)) DUT (
        .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .instr_exec_in(exec_w), .wdt_instr_in(wdt_w),
        .halt_in(halt_w), .stop_in(stop_w), .stop_mode_recovery_in(rec_w), .flags_out(flags),
        .flags_write_out(flags_wr), .otp_wdt_at_por_in(otp), .brownout_threshold_low_in(bo_low),
        .cpu_reset_out(cpu_rst), .watchdog_timer_running_out(running));

    wdb_core_model u_core (
        .clk_in(clk_in), .instr_exec_out(exec_w), .wdt_instr_out(wdt_w),
        .halt_out(halt_w), .stop_out(stop_w), .recovery_out(rec_w));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Zero-wait slave, but the master still waits for pready as the bus requires
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) @(posedge clk_in);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-drives the strobes in this time step
        @(posedge clk_in);
    endtask

    task automatic wait_rel();
        n = 0;
        while (cpu_rst !== 1'b0 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        check(cpu_rst, 1'b0);
        @(posedge clk_in);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        conclude();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        reset_in = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        otp = 1'b0;
        bo_low = 1'b0;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        wait_rel();
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check(rd[4:0], {1'b0, CAUSE_POR, 2'b00});
        apb(1'b0, MODE_ADDR, 32'h0000_0000);
        check({er, rd}, 33'h0_0000_0000);
        apb(1'b0, STATUS_ADDR + 12'h004, 32'h0000_0000);
        check(er, 1'b1);
        $display("test reset done");
        // Default mode keeps counting in stop, on the RC clock
        u_core.refresh();
        @(posedge clk_in);
        check({flags_wr, flags, running}, {1'b1, REFRESH_FLAGS, 1'b1});
        u_core.stop_out <= 1'b1;
        n = 0;
        while (cpu_rst !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            n++;
        end
        check(cpu_rst, 1'b1);
        u_core.stop_out <= 1'b0;
        wait_rel();
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check({rd[31:16], rd[3:2], rd[0]}, {16'h0000, CAUSE_WDT, 1'b0});
        $display("test stop done");
        // Reserved bits set, low nibble clear: tap 0, no halt count
        u_core.exec();
        apb(1'b1, MODE_ADDR, 32'h0000_00F0);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check(rd[1], 1'b1);
        repeat (130) @(posedge clk_in);
        apb(1'b1, MODE_ADDR, 32'h0000_0003);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check(rd[1], 1'b0);
        // Stop recovery rearms the window; the next instruction opens it again
        u_core.recovery_out <= 1'b1;
        @(posedge clk_in);
        u_core.recovery_out <= 1'b0;
        u_core.exec();
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check(rd[1], 1'b1);
        repeat (100) @(posedge clk_in);
        check({cpu_rst, running}, 2'b00);
        $display("test window done");
        u_core.refresh();
        for (int i = 0; i < 10; i++) begin
            repeat (10) @(posedge clk_in);
            u_core.refresh();
        end
        check(cpu_rst, 1'b0);
        u_core.halt_out <= 1'b1;
        repeat (60) @(posedge clk_in);
        check(cpu_rst, 1'b0);
        u_core.halt_out <= 1'b0;
        // Mode bit 3 was cleared in the window, so stop freezes the count
        u_core.stop_out <= 1'b1;
        repeat (60) @(posedge clk_in);
        check(cpu_rst, 1'b0);
        u_core.stop_out <= 1'b0;
        u_core.refresh();
        n = 0;
        while (cpu_rst !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        // Tap 0 of RC ticks; a crystal-clocked or tap 3 counter misses this span
        check(1'(n >= T0 * RCD - 4 && n <= T0 * RCD + 8), 1'b1);
        wait_rel();
        $display("test timeout done");
        otp <= 1'b1;
        bo_low <= 1'b1;
        repeat (30) @(posedge clk_in);
        check(cpu_rst, 1'b1);
        bo_low <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(cpu_rst, 1'b1);
        wait_rel();
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check({rd[3:2], rd[0], running}, {CAUSE_BROWNOUT, 2'b11});
        $display("test brownout done");
        conclude();
    end
endmodule // wdb_watchdog_tb_top
